//--- shared/dtcs_pkg.sv
// constants and carrier types for the dma transfer cycle sequencer
`default_nettype none
package dtcs_pkg;
   localparam int DTCS_ADDR_W = 20;
   localparam int DTCS_WGT_W = 2;
   // area weights per access
   localparam logic [1:0] DTCS_WGT_PLAIN = 2'h1;
   localparam logic [1:0] DTCS_WGT_WAIT = 2'h2;
   localparam logic [1:0] DTCS_WGT_MUX = 2'h3;
   // accesses per phase: one whole unit, or two byte halves
   localparam logic [1:0] DTCS_ACC_ONE = 2'h1;
   localparam logic [1:0] DTCS_ACC_TWO = 2'h2;

   // kind of area an address falls in
   typedef enum logic [2:0] {
      DTCS_AREA_INT = 3'h0,
      DTCS_AREA_INT_WAIT = 3'h1,
      DTCS_AREA_SFA = 3'h2,
      DTCS_AREA_EXT = 3'h3,
      DTCS_AREA_EXT_WAIT = 3'h4,
      DTCS_AREA_MUX = 3'h5
   } dtcs_area_e;

   // one side (source or destination) of a transfer unit
   typedef struct packed {
      logic [DTCS_ADDR_W-1:0] addr;
      dtcs_area_e area;
   } dtcs_side_s;

   // bus access issued each bus cycle
   typedef struct packed {
      logic [DTCS_ADDR_W-1:0] addr;
      logic rd;
      logic wr;
      logic wide;
      logic dummy;
   } dtcs_bus_s;

   typedef enum logic [4:0] {
      DTCS_IDLE = 5'h01,
      DTCS_READ = 5'h02,
      DTCS_WRITE = 5'h04,
      DTCS_DUMMY = 5'h08,
      DTCS_DONE = 5'h10
   } dtcs_state_e;
endpackage
`default_nettype wire

//--- logic/dtcs_sequencer.sv
// bus cycle sequencer for one dma transfer unit
`timescale 1ns/1ps
`default_nettype none
module dtcs_sequencer
   import dtcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic bclk_en_in,
   input wire logic start_in,
   input wire logic word_unit_in,
   input wire logic narrow_pin_in,
   input wire logic expansion_mode_in,
   input wire dtcs_side_s src_in,
   input wire dtcs_side_s dst_in,
   output logic busy_out,
   output logic done_out,
   output dtcs_bus_s bus_out,
   output logic [3:0] cycle_count_out
);

   ////////////////////////////////////////////////////////////////////////
   // per-side access planning

   // narrow bus only outside single-chip mode; internal areas follow it too
   logic narrow;
   assign narrow = expansion_mode_in & narrow_pin_in;

   // accesses one side needs; word and width come in as arguments so that
   // the write phase plans from the values latched at the start of the unit
   function automatic logic [1:0] accesses(input logic word,
                                           input logic nar,
                                           input logic odd);
      logic [1:0] n;
      n = DTCS_ACC_ONE;
      // a word goes as two byte halves on a narrow bus or from an odd start
      if (word && (nar || odd)) begin
         n = DTCS_ACC_TWO;
      end
      return n;
   endfunction

   // bus cycles that one access of an area takes
   function automatic logic [1:0] weight(input dtcs_area_e ar);
      logic [1:0] w;
      w = DTCS_WGT_PLAIN;
      unique case (ar)
         DTCS_AREA_INT_WAIT, DTCS_AREA_SFA,
         DTCS_AREA_EXT_WAIT: w = DTCS_WGT_WAIT;
         DTCS_AREA_MUX: w = DTCS_WGT_MUX;
         default: w = DTCS_WGT_PLAIN;
      endcase
      return w;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sequencing state

   dtcs_state_e state;
   dtcs_side_s src;
   dtcs_side_s dst;
   logic word_unit;
   logic narrow_q;
   logic [1:0] acc_left;
   logic [1:0] wait_left;
   logic [1:0] acc_idx;

   ////////////////////////////////////////////////////////////////////////
   // step decode, shared by the state, counter and output blocks

   logic in_access; // reading or writing
   logic take; // start accepted on this bus clock
   logic stretch; // extra wait cycle of an access
   logic last_beat; // final bus cycle of an access
   logic more_acc; // second byte half follows
   logic open_write; // last read ends, writes begin
   logic close_write; // last write ends
   logic [1:0] dst_acc;
   logic [1:0] dst_wait;
   logic [1:0] cur_wait;

   // every step but in_access qualifies on the bus clock enable
   assign in_access = state == DTCS_READ || state == DTCS_WRITE;
   assign take = bclk_en_in && state == DTCS_IDLE && start_in;
   assign stretch = bclk_en_in && in_access && wait_left != 2'h0;
   assign last_beat = bclk_en_in && in_access && wait_left == 2'h0;
   assign more_acc = last_beat && acc_left != DTCS_ACC_ONE;
   assign open_write = last_beat && acc_left == DTCS_ACC_ONE
                       && state == DTCS_READ;
   assign close_write = last_beat && acc_left == DTCS_ACC_ONE
                        && state == DTCS_WRITE;

   // destination judged on its own address and area, never the source's
   assign dst_acc = accesses(word_unit, narrow_q,
                             dst.addr[0]);
   assign dst_wait = weight(dst.area) - 2'h1;
   // a waited access repeats its address, so each half reloads the wait
   assign cur_wait = weight(state == DTCS_WRITE ? dst.area : src.area)
                     - 2'h1;

   ////////////////////////////////////////////////////////////////////////
   // phase control and per-access counters

   // phase order: idle, reads, writes, dummy, done; one step per bus clock
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state <= DTCS_IDLE;
      end else if (bclk_en_in) begin
         unique case (state)
            DTCS_IDLE: begin
               if (start_in) begin
                  state <= DTCS_READ;
               end
            end
            DTCS_READ: begin
               if (open_write) begin
                  state <= DTCS_WRITE;
               end
            end
            DTCS_WRITE: begin
               if (close_write) begin
                  state <= DTCS_DUMMY;
               end
            end
            DTCS_DUMMY: state <= DTCS_DONE;
            DTCS_DONE: state <= DTCS_IDLE;
            // a corrupted one-hot code falls back to idle
            default: state <= DTCS_IDLE;
         endcase
      end
   end

   // unit conditions latched on take, so a mid-unit pin change is harmless
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         src <= '0;
         dst <= '0;
         word_unit <= 1'b0;
         narrow_q <= 1'b0;
      end else if (take) begin
         src <= src_in;
         dst <= dst_in;
         word_unit <= word_unit_in;
         narrow_q <= narrow;
      end
   end

   // accesses still to issue in the current phase
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         acc_left <= 2'h0;
      end else if (take) begin
         acc_left <= accesses(word_unit_in, narrow, src_in.addr[0]);
      end else if (more_acc) begin
         acc_left <= acc_left - 2'h1;
      end else if (open_write) begin
         acc_left <= dst_acc;
      end
   end

   // byte half being issued; offsets the side's start address
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         acc_idx <= 2'h0;
      end else if (take || open_write) begin
         acc_idx <= 2'h0;
      end else if (more_acc) begin
         acc_idx <= acc_idx + 2'h1;
      end
   end

   // wait cycles left in the current access
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         wait_left <= 2'h0;
      end else if (take) begin
         wait_left <= weight(src_in.area) - 2'h1;
      end else if (stretch) begin
         wait_left <= wait_left - 2'h1;
      end else if (more_acc) begin
         wait_left <= cur_wait;
      end else if (open_write) begin
         wait_left <= dst_wait;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // bus cycle counter, observable total per unit

   // dummy and done cycles are left out of the total on purpose
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cycle_count_out <= 4'h0;
      end else if (take) begin
         cycle_count_out <= 4'h0;
      end else if (bclk_en_in && in_access) begin
         cycle_count_out <= cycle_count_out + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered bus outputs, one clock behind the state

   logic [DTCS_ADDR_W-1:0] cur_addr;
   logic single_word;

   // the second half addresses the byte after the side's start
   always_comb begin
      cur_addr = (state == DTCS_WRITE) ? dst.addr : src.addr;
      cur_addr = cur_addr + DTCS_ADDR_W'(acc_idx);
   end

   // word lane only for an unsplit, aligned word access
   assign single_word = word_unit && !narrow_q
                        && acc_left == DTCS_ACC_ONE
                        && acc_idx == 2'h0 && !cur_addr[0];

   // strobes follow the phase; lane gated so idle and dummy show no width
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         bus_out <= '0;
      end else begin
         bus_out.addr <= cur_addr;
         bus_out.rd <= state == DTCS_READ;
         bus_out.wr <= state == DTCS_WRITE;
         bus_out.wide <= in_access && single_word;
         bus_out.dummy <= state == DTCS_DUMMY;
      end
   end

   // done pulses one clock after the done bus cycle has passed
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         done_out <= 1'b0;
      end else begin
         done_out <= bclk_en_in && state == DTCS_DONE;
      end
   end

   // busy holds the bus away from the processor until the done cycle completes
   assign busy_out = state != DTCS_IDLE;

endmodule
`default_nettype wire

//--- tb/dtcs_sequencer_asserts.sv
// port checks for the transfer cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dtcs_sequencer_asserts
   import dtcs_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic bclk_en_in,
   input wire logic start_in,
   input wire logic narrow_pin_in,
   input wire logic expansion_mode_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire dtcs_bus_s bus_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   // an accepted start, seen as an idle bclk edge with start high
   sequence s_take;
      start_in && bclk_en_in && !busy_out;
   endsequence
   // reads end on the edge that opens the write phase
   sequence s_rd_end;
      $fell(bus_out.rd);
   endsequence
   AST_TAKE: assert property (s_take |=> busy_out)
      else $error("start not taken");
   AST_FIRST_RD: assert property (s_take |-> ##[1:3] bus_out.rd)
      else $error("no read after start");
   AST_WR_AFTER_RD: assert property ($rose(bus_out.wr) |-> s_rd_end)
      else $error("write not after read");
   // four clocks is one bus clock with the bench divider
   AST_HOLD: assert property ($rose(bus_out.rd) |-> bus_out.rd[*4])
      else $error("read shorter than bus clock");
   AST_NARROW: assert property (bus_out.rd && narrow_pin_in
      && expansion_mode_in |-> !bus_out.wide) else $error("wide on 8-bit bus");
   AST_DUMMY_ALONE: assert property (bus_out.dummy |-> !bus_out.rd
      && !bus_out.wr) else $error("dummy with access");
   AST_DUMMY_NEXT: assert property ($fell(bus_out.wr) |-> bus_out.dummy)
      else $error("no dummy after write");
   AST_DONE: assert property ($fell(bus_out.dummy) |-> ##[1:8] done_out)
      else $error("no done after dummy");
   AST_WIDE_ACC: assert property (bus_out.wide |-> bus_out.rd || bus_out.wr)
      else $error("wide lane outside an access");
endmodule
`default_nettype wire

//--- tb/dtcs_bus_model.sv
// bus clock source: one enable pulse per bus clock
`timescale 1ns/1ps
`default_nettype none
module dtcs_bus_model
   import dtcs_pkg::*;
#(
   parameter int DIV = 4
)(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   output logic bclk_en_out
);
   logic [3:0] tick;
   // free running divider, bus clock never stops
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) tick <= 4'h0;
      else tick <= (tick == 4'(DIV - 1)) ? 4'h0 : tick + 4'h1;
   end
   assign bclk_en_out = (tick == 4'h0);
endmodule
`default_nettype wire

//--- tb/dtcs_sequencer_tb.sv
// self-checking bench for the transfer cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module dtcs_sequencer_tb
   import dtcs_pkg::*;
;
   logic clk_in = 1'h0;
   logic sys_rst_in = 1'h1;
   logic start = 1'h0, word = 1'h0, narrow = 1'h0, expm = 1'h0;
   logic bclk, busy, done;
   dtcs_side_s src = '0, dst = '0;
   dtcs_bus_s bus;
   logic [3:0] count;
   int bad_count = 0, compares = 0;
   always #10 clk_in = ~clk_in;
   dtcs_bus_model #(.DIV(4)) model (.clk_in(clk_in),
      .sys_rst_in(sys_rst_in), .bclk_en_out(bclk));
   dtcs_sequencer uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
      .bclk_en_in(bclk), .start_in(start), .word_unit_in(word),
      .narrow_pin_in(narrow), .expansion_mode_in(expm), .src_in(src),
      .dst_in(dst), .busy_out(busy), .done_out(done), .bus_out(bus),
      .cycle_count_out(count));
   task automatic conclude;
      $display("mismatches %0d of %0d checks", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what,
                        input logic [DTCS_ADDR_W-1:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // one unit; bus clocks spent busy are counted at the falling edge, and
   // the first read and first write are kept for address and lane checks
   task automatic unit(input logic w, n, e, input dtcs_side_s s, d,
                       input logic [7:0] x);
      int p;
      logic b, got_rd, got_wr;
      dtcs_bus_s first_rd, first_wr;
      logic [DTCS_ADDR_W-1:0] xw, seen, rd_lane, wr_lane;
      p = 0;
      got_rd = 1'h0;
      got_wr = 1'h0;
      first_rd = '0;
      first_wr = '0;
      xw = DTCS_ADDR_W'(x);
      // wide lane only for an unsplit aligned word; pin ignored single-chip
      rd_lane = DTCS_ADDR_W'(w & ~(n & e) & ~s.addr[0]);
      wr_lane = DTCS_ADDR_W'(w & ~(n & e) & ~d.addr[0]);
      @(posedge clk_in);
      {word, narrow, expm, src, dst, start} <= {w, n, e, s, d, 1'h1};
      for (int i = 0; i < 200; i++) begin
         @(negedge clk_in);
         b = busy;
         if (bus.rd === 1'h1 && !got_rd) begin
            got_rd = 1'h1;
            first_rd = bus;
         end
         if (bus.wr === 1'h1 && !got_wr) begin
            got_wr = 1'h1;
            first_wr = bus;
         end
         if (done === 1'h1) break;
         if (b === 1'h1 && bclk === 1'h1) p++;
         @(posedge clk_in);
         if (b === 1'h1) start <= 1'h0;
         if (i == 199) begin
            bad_count++;
            conclude();
         end
      end
      check("access cycles", DTCS_ADDR_W'(count), xw);
      check("bus cycles busy", DTCS_ADDR_W'(p), xw + 20'h2);
      check("read address", first_rd.addr, s.addr);
      check("write address", first_wr.addr, d.addr);
      seen = DTCS_ADDR_W'(first_rd.wide);
      check("read lane", seen, rd_lane);
      seen = DTCS_ADDR_W'(first_wr.wide);
      check("write lane", seen, wr_lane);
   endtask
   task automatic sc_align;
      unit(1'h1, 1'h0, 1'h0, '{20'h00100, DTCS_AREA_INT},
         '{20'h00200, DTCS_AREA_INT}, 8'h02);
      unit(1'h1, 1'h0, 1'h0, '{20'h00101, DTCS_AREA_INT},
         '{20'h00201, DTCS_AREA_INT}, 8'h04);
   endtask
   // narrow pin splits internal words only in expansion modes
   task automatic sc_narrow;
      unit(1'h1, 1'h1, 1'h1, '{20'h00100, DTCS_AREA_INT},
         '{20'h00200, DTCS_AREA_INT}, 8'h04);
      unit(1'h1, 1'h1, 1'h0, '{20'h00100, DTCS_AREA_INT},
         '{20'h00200, DTCS_AREA_INT}, 8'h02);
      unit(1'h0, 1'h1, 1'h1, '{20'h00700, DTCS_AREA_EXT},
         '{20'h00801, DTCS_AREA_INT}, 8'h02);
   endtask
   task automatic sc_wait;
      unit(1'h0, 1'h0, 1'h0, '{20'h00300, DTCS_AREA_SFA},
         '{20'h00401, DTCS_AREA_EXT_WAIT}, 8'h04);
      unit(1'h1, 1'h0, 1'h1, '{20'h00500, DTCS_AREA_MUX},
         '{20'h00601, DTCS_AREA_INT_WAIT}, 8'h07);
   endtask
   initial begin
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'h0;
      sc_align();
      sc_narrow();
      sc_wait();
      conclude();
   end
endmodule
bind dtcs_sequencer dtcs_sequencer_asserts chk (.clk_in(clk_in),
   .sys_rst_in(sys_rst_in), .bclk_en_in(bclk_en_in), .start_in(start_in),
   .narrow_pin_in(narrow_pin_in), .expansion_mode_in(expansion_mode_in),
   .busy_out(busy_out), .done_out(done_out), .bus_out(bus_out));
`default_nettype wire
